// ===== spgc_pin_gpio.sv
`include "spgc_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module spgc_pin_gpio #(
    parameter int PIN_COUNT = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Register port
    input wire spgc_pkg::spgc_req_s busReq,
    output var spgc_pkg::spgc_byte_t rdData,
    // Scan strap from nonvolatile configuration
    input wire logic scanActive,
    // Normal functions of the pins
    input wire logic clockFunc,
    input wire logic [3:0] scanOutFunc,
    input wire logic [3:0] scanOutEnN,
    output var logic clockFuncOn,
    // Pad ring
    input wire spgc_pkg::spgc_byte_t pin_input_sample,
    output var spgc_pkg::spgc_pad_s padDrive
);

    // ********************************************
    // Elaboration check
    // ********************************************
    if (PIN_COUNT != 8) begin : g_bad_count
        $error("Pin count must be 8");
    end

    // ********************************************
    // Behaviour notes
    // ********************************************
    // Register map, one byte each:
    //   output enable  - read/write, one bit per pin
    //   output value   - read/write, same bit order
    //   input sample   - read only, writes are dropped
    // Bit order in all three registers:
    //   7 signal input pin
    //   6 clock output pin
    //   5 select line 1 pin
    //   4 select line 0 pin
    //   3 scan clock pin
    //   2 scan mode pin
    //   1 scan data in pin
    //   0 scan data out pin
    // Timing seen from the register port:
    //   a write lands in its register at the next edge
    //   the pads follow one edge after the register
    //   read data stands only in the cycle after the strobe
    //   the input sample is one flop deep, so a read shows
    //   the pad level from one edge before the data appears
    // Limitations a user must know:
    //   the scan strap masks the scan enables but leaves the
    //   stored bits readable, so software cannot tell from a
    //   read whether its enables are in force
    //   the clock pin is always an output; enabling it only
    //   swaps the clock for the value bit
    //   pads are registered for clean timing at the ring, at
    //   the cost of one cycle of extra latency
    // Trade-off: no synchroniser on the pad inputs; the block
    // takes them as already synchronous to clk

    spgc_pkg::spgc_byte_t outEnable_reg;
    spgc_pkg::spgc_byte_t outEnable_next;
    spgc_pkg::spgc_byte_t outValue_reg;
    spgc_pkg::spgc_byte_t outValue_next;
    spgc_pkg::spgc_byte_t inSample_reg;
    spgc_pkg::spgc_byte_t rdData_next;
    spgc_pkg::spgc_pad_s pad_next;
    logic clockFuncOn_next;
    logic checkArmed_reg;

    // ********************************************
    // Register decode
    // ********************************************
    // Writes to the read-only sample address are dropped silently
    wire hitEnable = busReq.addr == `SPGC_OFS_OUT_ENABLE;
    wire hitValue = busReq.addr == `SPGC_OFS_OUT_VALUE;
    wire hitSample = busReq.addr == `SPGC_OFS_IN_SAMPLE;
    assign outEnable_next = (busReq.wr && hitEnable) ? busReq.wdata : outEnable_reg;
    assign outValue_next = (busReq.wr && hitValue) ? busReq.wdata : outValue_reg;
    // Unmapped reads return zero; data stands one cycle only
    assign rdData_next = !busReq.rd ? 8'h00 :
                         hitEnable ? outEnable_reg :
                         hitValue ? outValue_reg :
                         hitSample ? inSample_reg : 8'h00;

    // ********************************************
    // Effective enables
    // ********************************************
    // The strap masks the scan bits instead of altering the stored value
    wire [7:0] scanMask = scanActive ? `SPGC_SCAN_MASK : 8'h00;
    wire [7:0] effEnable = outEnable_reg & ~scanMask;
    assign clockFuncOn_next = !outEnable_reg[`SPGC_BIT_CLOCK_OUTPUT_PIN];

    // Per pin: register drive when enabled, else the pin's own function
    for (genvar i = 0; i < PIN_COUNT; i++) begin : g_pin
        if (i < 4) begin : g_scan
            // Scan pins fall back to the scan logic's own drive
            assign pad_next.value[i] = effEnable[i] ? outValue_reg[i] : scanOutFunc[i];
            assign pad_next.enableN[i] = effEnable[i] ? 1'b0 : scanOutEnN[i];
        end else if (i == `SPGC_BIT_CLOCK_OUTPUT_PIN) begin : g_clk
            assign pad_next.value[i] = effEnable[i] ? outValue_reg[i] : clockFunc;
            assign pad_next.enableN[i] = 1'b0;
        end else begin : g_in
            // Signal input and select straps are inputs unless enabled
            assign pad_next.value[i] = outValue_reg[i];
            assign pad_next.enableN[i] = !effEnable[i];
        end
    end

    // ********************************************
    // Registers
    // ********************************************
    // Software registers
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            outEnable_reg <= `SPGC_RST_OUT_ENABLE;
            outValue_reg <= `SPGC_RST_OUT_VALUE;
        end else begin
            outEnable_reg <= outEnable_next;
            outValue_reg <= outValue_next;
        end
    end

    // Input sample and read data
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            inSample_reg <= 8'h00;
            rdData <= 8'h00;
        end else begin
            inSample_reg <= pin_input_sample;
            rdData <= rdData_next;
        end
    end

    // Pad outputs come from flops; one cycle behind the registers
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            padDrive <= '{value: 8'h00, enableN: 8'hbf};
            clockFuncOn <= 1'b1;
        end else begin
            padDrive <= pad_next;
            clockFuncOn <= clockFuncOn_next;
        end
    end

    // Arms the pad checks one cycle after reset; no hardware use
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            checkArmed_reg <= 1'b0;
        end else begin
            checkArmed_reg <= 1'b1;
        end
    end

    // ********************************************
    // Assertions
    // ********************************************
    // Pad checks that compare with $past of scanOutEnN, scanOutFunc or clockFunc wait for checkArmed_reg,
    // so they never compare against inputs seen during reset
    a_external_signal_input_pin_drive: assert property (@(posedge clk) disable iff (!reset_n)
        $past(outEnable_reg[7]) |-> !padDrive.enableN[7])
        else $error("Signal input pin not driven when enabled");

    // Clock function stops and the value bit takes the pin
    a_clock_off: assert property (@(posedge clk) disable iff (!reset_n)
        $past(outEnable_reg[6]) |-> !clockFuncOn && padDrive.value[6] == $past(outValue_reg[6]))
        else $error("Clock output not replaced by value");

    // Both select pins become outputs together
    a_select_drive: assert property (@(posedge clk) disable iff (!reset_n)
        $past(outEnable_reg[5:4]) == 2'b11 |-> padDrive.enableN[5:4] == 2'b00)
        else $error("Select pins not driven");

    // Scan data out pin follows its value bit without the strap
    a_scan_drive: assert property (@(posedge clk) disable iff (!reset_n)
        ($past(outEnable_reg[0]) && !$past(scanActive)) |->
        !padDrive.enableN[0] && padDrive.value[0] == $past(outValue_reg[0]))
        else $error("Scan pin not driven by value");

    // Under the strap the scan logic owns all four enables
    a_strap_block: assert property (@(posedge clk) disable iff (!reset_n)
        (checkArmed_reg && $past(scanActive)) |-> padDrive.enableN[3:0] == $past(scanOutEnN))
        else $error("Scan pin enable not ignored under strap");

    // A value write lands at the next edge
    a_value_write: assert property (@(posedge clk) disable iff (!reset_n)
        (busReq.wr && hitValue) |=> outValue_reg == $past(busReq.wdata))
        else $error("Value register not written");

    // Sample read returns the flop seen with the strobe
    a_sample_read: assert property (@(posedge clk) disable iff (!reset_n)
        (busReq.rd && hitSample) |=> rdData == $past(inSample_reg))
        else $error("Sample read mismatch");

    // Signal input pin stays an input while its enable is clear
    a_idle_input: assert property (@(posedge clk) disable iff (!reset_n)
        !$past(outEnable_reg[7]) |-> padDrive.enableN[7])
        else $error("Pin driven while enable clear");

    // Read data stands one cycle only; zero otherwise
    a_read_idle: assert property (@(posedge clk) disable iff (!reset_n)
        !busReq.rd |=> rdData == 8'h00)
        else $error("Read data not zero outside a read");

    // An enable write lands at the next edge
    a_enable_write: assert property (@(posedge clk) disable iff (!reset_n)
        (busReq.wr && hitEnable) |=> outEnable_reg == $past(busReq.wdata))
        else $error("Enable register not written");

    // Writes to the sample address change no register
    a_sample_ro: assert property (@(posedge clk) disable iff (!reset_n)
        (busReq.wr && hitSample) |=>
        outEnable_reg == $past(outEnable_reg) && outValue_reg == $past(outValue_reg))
        else $error("Read-only write changed a register");

    // Enable reads show the stored bits even under the strap
    a_enable_read: assert property (@(posedge clk) disable iff (!reset_n)
        (busReq.rd && hitEnable) |=> rdData == $past(outEnable_reg))
        else $error("Enable read mismatch");

    // With the enable clear the clock function keeps the pin
    a_clock_keep: assert property (@(posedge clk) disable iff (!reset_n)
        (checkArmed_reg && !$past(outEnable_reg[6])) |->
        clockFuncOn && padDrive.value[6] == $past(clockFunc))
        else $error("Clock function lost while enable clear");

    // The clock pin is an output in both of its roles
    a_clock_driven: assert property (@(posedge clk) disable iff (!reset_n)
        !padDrive.enableN[6])
        else $error("Clock pin released");

    // Select pins released while both enables are clear
    a_select_idle: assert property (@(posedge clk) disable iff (!reset_n)
        $past(outEnable_reg[5:4]) == 2'b00 |-> padDrive.enableN[5:4] == 2'b11)
        else $error("Select pins driven while enable clear");

    // Signal input pin level comes from its value bit
    a_external_signal_input_pin_value: assert property (@(posedge clk) disable iff (!reset_n)
        $past(outEnable_reg[7]) |-> padDrive.value[7] == $past(outValue_reg[7]))
        else $error("Signal input pin level wrong");

    // Every scan pin: value drive when free, scan logic otherwise
    for (genvar j = 0; j < 4; j++) begin : g_scan_chk
        a_scan_value: assert property (@(posedge clk) disable iff (!reset_n)
            ($past(outEnable_reg[j]) && !$past(scanActive)) |->
            !padDrive.enableN[j] && padDrive.value[j] == $past(outValue_reg[j]))
            else $error("Scan pin value drive wrong");
        a_scan_fallback: assert property (@(posedge clk) disable iff (!reset_n)
            (checkArmed_reg && (!$past(outEnable_reg[j]) || $past(scanActive))) |->
            padDrive.enableN[j] == $past(scanOutEnN[j]) &&
            padDrive.value[j] == $past(scanOutFunc[j]))
            else $error("Scan pin not left to scan logic");
    end

    // Main scenarios
    c_clock_takeover: cover property (@(posedge clk) disable iff (!reset_n)
        $rose(outEnable_reg[6]) ##1 !clockFuncOn);
    c_strap_write: cover property (@(posedge clk) disable iff (!reset_n)
        scanActive && busReq.wr && hitEnable);
    c_back_to_back: cover property (@(posedge clk) disable iff (!reset_n)
        busReq.wr ##1 busReq.rd);
    c_scan_masked: cover property (@(posedge clk) disable iff (!reset_n)
        checkArmed_reg && scanActive && outEnable_reg[3:0] == 4'hf);
    c_unmapped_read: cover property (@(posedge clk) disable iff (!reset_n)
        busReq.rd && !hitEnable && !hitValue && !hitSample);

endmodule : spgc_pin_gpio

`default_nettype wire

// ===== spgc_cfg.svh
`ifndef SPGC_CFG_SVH
`define SPGC_CFG_SVH

// ********************************************
// Register map
// ********************************************
`define SPGC_ADDR_W 8
`define SPGC_OFS_OUT_ENABLE 8'h44
`define SPGC_OFS_OUT_VALUE 8'h45
`define SPGC_OFS_IN_SAMPLE 8'h46
`define SPGC_RST_OUT_ENABLE 8'h00
`define SPGC_RST_OUT_VALUE 8'h00

// ********************************************
// Pin positions in every register
// ********************************************
`define SPGC_BIT_EXTERNAL_SIGNAL_INPUT_PIN 7
`define SPGC_BIT_CLOCK_OUTPUT_PIN 6
`define SPGC_BIT_SEL1 5
`define SPGC_BIT_SEL0 4
`define SPGC_BIT_TCK 3
`define SPGC_BIT_TMS 2
`define SPGC_BIT_TDI 1
`define SPGC_BIT_TDO 0
`define SPGC_SCAN_MASK 8'h0f

`endif

// ===== spgc_pkg.sv
`default_nettype none

// ********************************************
// Types shared by the pin block
// ********************************************
package spgc_pkg;
    typedef logic [7:0] spgc_byte_t;

    // Register bus request from software
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } spgc_req_s;

    // Per-pin drive towards the pad ring
    typedef struct packed {
        spgc_byte_t value;
        spgc_byte_t enableN;
    } spgc_pad_s;
endpackage : spgc_pkg

`default_nettype wire

// ===== tb.sv
`include "spgc_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

// ********************************************
// Random register and pad traffic bench
// ********************************************
module tb;
    logic clk, reset_n, scanActive, clockFunc, clockFuncOn;
    logic [3:0] scanOutFunc, scanOutEnN;
    spgc_pkg::spgc_req_s busReq;
    spgc_pkg::spgc_byte_t rdData, pin_input_sample, en, val;
    spgc_pkg::spgc_pad_s padDrive;
    logic [15:0] e;
    int n_errors, comparisons, seed, i;

    spgc_pin_gpio i_dut (.clk(clk), .reset_n(reset_n), .busReq(busReq), .rdData(rdData),
        .scanActive(scanActive), .clockFunc(clockFunc), .scanOutFunc(scanOutFunc),
        .scanOutEnN(scanOutEnN), .clockFuncOn(clockFuncOn), .pin_input_sample(pin_input_sample),
        .padDrive(padDrive));

    // Free-running 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Expected pad value and active-low enable, value masked where released
    function automatic logic [15:0] expPad(input logic [7:0] en, val, input logic sc, cf,
        input logic [3:0] so, soe);
        logic [3:0] g;
        logic [7:0] v, n;
        g = en[3:0] & {4{~sc}};
        n = {~en[7], 1'b0, ~en[5:4], soe & ~g};
        v = {val[7], en[6] ? val[6] : cf, val[5:4], (val[3:0] & g) | (so & ~g)};
        return {v & ~n, n};
    endfunction : expPad

    task automatic chk8(input logic [7:0] got, exp, input string msg);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : chk8

    // One-cycle strobes; a gap cycle follows each access
    task automatic wr(input logic [7:0] a, d);
        @(posedge clk);
        busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        busReq.wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, exp);
        @(posedge clk);
        busReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        busReq.rd <= 1'b0;
        #1 chk8(rdData, exp, "read");
    endtask : rd

    task automatic stop_test;
        $display("comparisons %0d, mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : stop_test

    // Watchdog: the whole run needs well under 2000 cycles
    initial begin
        #20000;
        n_errors++;
        stop_test();
    end

    // Main sequence: reset, then corner patterns followed by random ones
    initial begin
        n_errors = 0;
        comparisons = 0;
        seed = 98;
        reset_n = 1'b0;
        busReq = '0;
        {scanActive, clockFunc, scanOutFunc, scanOutEnN, pin_input_sample} = '0;
        repeat (6) @(posedge clk);
        reset_n <= 1'b1;
        #1 chk8(padDrive.enableN, 8'hbf, "reset enable");
        chk8({7'h00, clockFuncOn}, 8'h01, "reset clock");
        rd(`SPGC_OFS_OUT_ENABLE, `SPGC_RST_OUT_ENABLE);
        for (i = 0; i < 24; i++) begin
            @(posedge clk);
            e = 16'($random(seed));
            if (i < 2) e[9] = i[0];
            {scanActive, clockFunc, scanOutFunc, scanOutEnN} <= e[9:0];
            pin_input_sample <= 8'($random(seed));
            {en, val} = 16'($random(seed));
            if (i < 3) en = (i == 2) ? 8'h00 : 8'hff;
            wr(`SPGC_OFS_OUT_ENABLE, en);
            wr(`SPGC_OFS_OUT_VALUE, val);
            wr(`SPGC_OFS_IN_SAMPLE, ~pin_input_sample);
            repeat (2) @(posedge clk);
            #1 e = expPad(en, val, scanActive, clockFunc, scanOutFunc, scanOutEnN);
            chk8(padDrive.enableN, e[7:0], "pad enable");
            chk8(padDrive.value & ~e[7:0], e[15:8], "pad value");
            chk8({7'h00, clockFuncOn}, {7'h00, ~en[6]}, "clock function");
            rd(`SPGC_OFS_OUT_ENABLE, en);
            rd(`SPGC_OFS_OUT_VALUE, val);
            rd(`SPGC_OFS_IN_SAMPLE, pin_input_sample);
            rd(8'h47, 8'h00);
            $display("test %0d done", i);
        end
        stop_test();
    end
endmodule : tb

`default_nettype wire
